// ### rtl/timer2_pkg.sv
package timer2_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CONTROL = 12'h0c8;
   localparam logic [11:0] ADDR_COUNT   = 12'h0cc;
   localparam logic [11:0] ADDR_CAPTURE = 12'h0d0;
   localparam logic [11:0] ADDR_MODE    = 12'h0d4;
   localparam logic [11:0] ADDR_IRQSTAT = 12'h0d8;
   localparam logic [11:0] ADDR_IRQMASK = 12'h0dc;

   // ----------------------------------------------------------------
   // Control register fields and reset values
   // ----------------------------------------------------------------
   localparam int BIT_OVF_FLAG   = 7;
   localparam int BIT_EXT_FLAG   = 6;
   localparam int BIT_RX_CLK_SEL = 5;
   localparam int BIT_TX_CLK_SEL = 4;
   localparam int BIT_EXT_EN     = 3;
   localparam int BIT_RUN        = 2;
   localparam int BIT_SRC_SEL    = 1;
   localparam int BIT_CAP_SEL    = 0;

   // Mode register: bit 0 down count enable, bit 1 six-clock mode
   localparam int BIT_DOWN_EN    = 0;
   localparam int BIT_SIX_CLK    = 1;

   // Interrupt status/mask: bit 0 overflow, bit 1 external trigger
   localparam int IRQ_OVF        = 0;
   localparam int IRQ_EXT        = 1;

   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [1:0]  IRQ_RESET     = 2'h0;

   // ----------------------------------------------------------------
   // Prescale counts (oscillator cycles per count step)
   // ----------------------------------------------------------------
   localparam int DIV_TWELVE = 12;
   localparam int DIV_SIX    = 6;

endpackage : timer2_pkg

// ### rtl/pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clkEnable,
   // Pin
   input  wire logic pinIn,
   // Result
   output logic      pinLevel,
   output logic      fallPulse
);

   logic syncFirst;
   logic syncSecond;

   // Two stages, then the edge compare on the second and third only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         syncFirst  <= 1'b1;
         syncSecond <= 1'b1;
         pinLevel   <= 1'b1;
      end else if (clkEnable) begin
         syncFirst  <= pinIn;
         syncSecond <= syncFirst;
         pinLevel   <= syncSecond;
      end
   end

   assign fallPulse = clkEnable & pinLevel & ~syncSecond;

endmodule : pin_edge_detect

`default_nettype wire

// ### rtl/timer2_mode_control.sv
// Contract
// - Overflow sets control bit 7; only a software zero write clears it.
// - No overflow flag while receive or transmit clock select is one.
// - Trigger falling edge causing capture or reload sets bit 6.
// - Interrupt requested while external flag set and enabled; flag sticky.
// - Down count enable blocks the external flag interrupt.
// - Receive clock select picks this timer's overflows, else other timer's.
// - Transmit clock select picks this timer's overflows, else other timer's.
// - Counts only while run bit is one; mode bits never start it.
// - Source zero counts oscillator divided by twelve or six.
// - Source one counts each falling edge on the count pin.
// - Capture select with trigger enable captures on trigger falling edge.
// - Reload select reloads on overflow, and on trigger edge if enabled.
// - Serial clock select ignores capture select; reload only on overflow.
// - Capture copies the count into capture registers, counting continues.
// - Reload loads the capture registers into the count.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module timer2_mode_control
   import timer2_pkg::*;
#(
   parameter int PRESCALE_W = 4
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        clkEnable,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Pins
   input  wire logic        trigger_pin,
   input  wire logic        ext_count_pin,
   // Serial port baud clocks
   input  wire logic        otherTimerOverflow,
   output logic             rxBaudPulse,
   output logic             txBaudPulse,
   // Interrupt
   output logic             timerIrq
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (PRESCALE_W < 4) begin : g_check
      $error("PRESCALE_W must hold a count of twelve");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  timer_control_register;
   logic [1:0]  timer_mode_register;
   logic [7:0]  count_low;
   logic [7:0]  count_high;
   logic [7:0]  capture_low;
   logic [7:0]  capture_high;
   logic [1:0]  irqStatus;
   logic [1:0]  irqMask;
   logic [PRESCALE_W-1:0] prescale;

   logic        trigLevel;
   logic        trigFall;
   logic        countFall;

   logic        timer_overflow_flag;
   logic        ext_trigger_flag;
   logic        rx_clock_select;
   logic        tx_clock_select;
   logic        ext_trigger_enable;
   logic        run_control;
   logic        count_source_select;
   logic        capture_reload_select;
   logic        down_count_enable;
   logic        sixClockMode;

   assign timer_overflow_flag   = timer_control_register[BIT_OVF_FLAG];
   assign ext_trigger_flag      = timer_control_register[BIT_EXT_FLAG];
   assign rx_clock_select       = timer_control_register[BIT_RX_CLK_SEL];
   assign tx_clock_select       = timer_control_register[BIT_TX_CLK_SEL];
   assign ext_trigger_enable    = timer_control_register[BIT_EXT_EN];
   assign run_control           = timer_control_register[BIT_RUN];
   assign count_source_select   = timer_control_register[BIT_SRC_SEL];
   assign capture_reload_select = timer_control_register[BIT_CAP_SEL];
   assign down_count_enable     = timer_mode_register[BIT_DOWN_EN];
   assign sixClockMode          = timer_mode_register[BIT_SIX_CLK];

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pin_edge_detect u_trig (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .clkEnable (clkEnable),
      .pinIn     (trigger_pin),
      .pinLevel  (trigLevel),
      .fallPulse (trigFall)
   );

   pin_edge_detect u_count (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .clkEnable (clkEnable),
      .pinIn     (ext_count_pin),
      .pinLevel  (),
      .fallPulse (countFall)
   );

   // ----------------------------------------------------------------
   // Count step decode
   // ----------------------------------------------------------------
   logic [PRESCALE_W-1:0] divideBy;
   logic        prescaleTick;
   logic        countStep;
   logic        serialMode;
   logic        wrapNow;
   logic        overflowEvent;
   logic        extEvent;
   logic        captureEvent;
   logic        reloadEvent;
   logic [15:0] countNow;
   logic [15:0] next_count;
   logic        apbWrite;
   logic        apbRead;

   assign serialMode = rx_clock_select | tx_clock_select;
   assign divideBy   = sixClockMode ? PRESCALE_W'(DIV_SIX) : PRESCALE_W'(DIV_TWELVE);
   assign prescaleTick = (prescale == divideBy - PRESCALE_W'(1));
   // Baud-rate speed-up of the internal clock is left out; timer rate is kept
   assign countStep = clkEnable & run_control &
                      (count_source_select ? countFall : prescaleTick);
   assign countNow  = {count_high, count_low};
   assign wrapNow   = countStep & (countNow == 16'hffff);
   assign overflowEvent = wrapNow;
   assign extEvent  = clkEnable & trigFall & ext_trigger_enable;
   assign captureEvent = extEvent & capture_reload_select & ~serialMode;
   assign reloadEvent  = overflowEvent & (~capture_reload_select | serialMode)
                       | extEvent & ~capture_reload_select & ~serialMode;

   always_comb begin
      next_count = countNow;
      if (reloadEvent) begin
         next_count = {capture_high, capture_low};
      end else if (countStep) begin
         next_count = countNow + 16'h0001;
      end
   end

   // Writes land in the access phase; read data is latched at setup
   assign apbWrite = psel & penable & pwrite & pready;
   assign apbRead  = psel & ~penable & ~pwrite;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   // One compare per register, shared by the write strobes and the error response
   logic hitControl;
   logic hitCount;
   logic hitCapture;
   logic hitMode;
   logic hitIrqStat;
   logic hitIrqMask;
   logic addrMapped;
   logic wrControl;
   logic wrCount;
   logic wrCapture;
   logic wrMode;
   logic wrIrqStat;
   logic wrIrqMask;

   assign hitControl = (paddr == ADDR_CONTROL);
   assign hitCount   = (paddr == ADDR_COUNT);
   assign hitCapture = (paddr == ADDR_CAPTURE);
   assign hitMode    = (paddr == ADDR_MODE);
   assign hitIrqStat = (paddr == ADDR_IRQSTAT);
   assign hitIrqMask = (paddr == ADDR_IRQMASK);
   assign addrMapped = hitControl | hitCount | hitCapture | hitMode | hitIrqStat | hitIrqMask;

   // Writes to an unmapped offset decode to no strobe and are dropped
   assign wrControl  = apbWrite & hitControl;
   assign wrCount    = apbWrite & hitCount;
   assign wrCapture  = apbWrite & hitCapture;
   assign wrMode     = apbWrite & hitMode;
   assign wrIrqStat  = apbWrite & hitIrqStat;
   assign wrIrqMask  = apbWrite & hitIrqMask;

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prescale <= '0;
      end else if (clkEnable) begin
         if (!run_control || prescaleTick) begin
            prescale <= '0;
         end else begin
            prescale <= prescale + PRESCALE_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter and capture registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_low    <= COUNT_RESET[7:0];
         count_high   <= COUNT_RESET[15:8];
         capture_low  <= CAPTURE_RESET[7:0];
         capture_high <= CAPTURE_RESET[15:8];
      end else if (clkEnable) begin
         // Hardware update wins over a same-cycle software write to the count
         // A count write that meets a step is lost; software stops the timer first
         if (wrCount && !countStep && !reloadEvent) begin
            {count_high, count_low} <= pwdata[15:0];
         end else begin
            {count_high, count_low} <= next_count;
         end
         if (captureEvent) begin
            {capture_high, capture_low} <= countNow;
         end else if (wrCapture) begin
            {capture_high, capture_low} <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register with hardware flags
   // ----------------------------------------------------------------
   logic setOvf;
   logic setExt;
   assign setOvf = overflowEvent & ~serialMode;
   assign setExt = extEvent;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         timer_control_register <= CONTROL_RESET;
         timer_mode_register    <= MODE_RESET;
      end else if (clkEnable) begin
         if (wrControl) begin
            timer_control_register <= pwdata[7:0];
         end
         // Set beats a software clear in the same cycle
         if (setOvf) begin
            timer_control_register[BIT_OVF_FLAG] <= 1'b1;
         end
         if (setExt) begin
            timer_control_register[BIT_EXT_FLAG] <= 1'b1;
         end
         if (wrMode) begin
            timer_mode_register <= pwdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   logic [1:0] irqSet;
   logic [1:0] irqClear;
   assign irqSet[IRQ_OVF] = setOvf;
   assign irqSet[IRQ_EXT] = setExt;
   assign irqClear = wrIrqStat ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqStatus <= IRQ_RESET;
         irqMask   <= IRQ_RESET;
      end else if (clkEnable) begin
         irqStatus <= (irqStatus & ~irqClear) | irqSet;
         if (wrIrqMask) begin
            irqMask <= pwdata[1:0];
         end
      end
   end

   // The overflow flag, and the external flag unless down count is enabled, also hold the line until cleared there
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         timerIrq <= 1'b0;
      end else if (clkEnable) begin
         timerIrq <= (irqMask[IRQ_OVF] & (irqStatus[IRQ_OVF] | timer_overflow_flag))
                   | (irqMask[IRQ_EXT] & (irqStatus[IRQ_EXT] | ext_trigger_flag)
                      & ~down_count_enable);
      end
   end

   // ----------------------------------------------------------------
   // Serial port baud pulses
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxBaudPulse <= 1'b0;
         txBaudPulse <= 1'b0;
      end else if (clkEnable) begin
         rxBaudPulse <= rx_clock_select ? overflowEvent : otherTimerOverflow;
         txBaudPulse <= tx_clock_select ? overflowEvent : otherTimerOverflow;
      end else begin
         rxBaudPulse <= 1'b0;
         txBaudPulse <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: no wait states, read data registered in setup
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (clkEnable) begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pslverr <= !addrMapped;
         end
         if (apbRead) begin
            case (paddr)
               ADDR_CONTROL: prdata <= {24'h000000, timer_control_register};
               ADDR_COUNT:   prdata <= {16'h0000, countNow};
               ADDR_CAPTURE: prdata <= {16'h0000, capture_high, capture_low};
               ADDR_MODE:    prdata <= {30'h00000000, timer_mode_register};
               ADDR_IRQSTAT: prdata <= {30'h00000000, irqStatus};
               ADDR_IRQMASK: prdata <= {30'h00000000, irqMask};
               default:      prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : timer2_mode_control

`default_nettype wire

// ### verif/timer2_mode_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

module timer2_mode_control_properties
   import timer2_pkg::*;
#(
   parameter int PRESCALE_W = 4
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        clkEnable,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Pins, baud clocks, interrupt
   input wire logic        trigger_pin,
   input wire logic        ext_count_pin,
   input wire logic        otherTimerOverflow,
   input wire logic        rxBaudPulse,
   input wire logic        txBaudPulse,
   input wire logic        timerIrq
);
   logic       rxSel;
   logic       txSel;
   logic [1:0] maskCopy;
   logic       mapped;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   assign mapped = paddr inside {ADDR_CONTROL, ADDR_COUNT, ADDR_CAPTURE, ADDR_MODE, ADDR_IRQSTAT, ADDR_IRQMASK};

   // Shadow copies of the selects and the mask, taken where a write lands
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxSel    <= 1'b0;
         txSel    <= 1'b0;
         maskCopy <= 2'h0;
      end else if (clkEnable && psel && penable && pready && pwrite) begin
         if (paddr == ADDR_CONTROL) begin
            rxSel <= pwdata[BIT_RX_CLK_SEL];
            txSel <= pwdata[BIT_TX_CLK_SEL];
         end
         if (paddr == ADDR_IRQMASK) begin
            maskCopy <= pwdata[1:0];
         end
      end
   end

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rx_other;
      !rxSel && clkEnable ##1 !rxSel && clkEnable;
   endsequence
   sequence s_tx_other;
      !txSel && clkEnable ##1 !txSel && clkEnable;
   endsequence

   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_ready_once;
      pready |-> psel && penable ##1 !pready;
   endproperty
   property p_unmapped;
      pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   property p_mapped;
      pready && mapped |-> !pslverr;
   endproperty
   property p_rx_other;
      s_rx_other |-> rxBaudPulse == $past(otherTimerOverflow);
   endproperty
   property p_tx_other;
      s_tx_other |-> txBaudPulse == $past(otherTimerOverflow);
   endproperty
   property p_both_own;
      rxSel && txSel ##1 rxSel && txSel |-> rxBaudPulse == txBaudPulse;
   endproperty
   property p_frozen;
      !clkEnable |=> !rxBaudPulse && !txBaudPulse;
   endproperty
   property p_masked;
      maskCopy == 2'h0 ##1 maskCopy == 2'h0 |-> !timerIrq;
   endproperty

   a_answer:     assert property (p_answer) else $error("no ready after setup");
   a_ready_once: assert property (p_ready_once) else $error("ready outside one access cycle");
   a_unmapped:   assert property (p_unmapped) else $error("unmapped access not refused");
   a_mapped:     assert property (p_mapped) else $error("mapped access refused");
   a_rx_other:   assert property (p_rx_other) else $error("rx clock not from other timer");
   a_tx_other:   assert property (p_tx_other) else $error("tx clock not from other timer");
   a_both_own:   assert property (p_both_own) else $error("rx and tx own clocks differ");
   a_frozen:     assert property (p_frozen) else $error("baud pulse while frozen");
   a_masked:     assert property (p_masked) else $error("interrupt with all masked");
endmodule // timer2_mode_control_properties

bind timer2_mode_control timer2_mode_control_properties #(.PRESCALE_W(PRESCALE_W)) checker_inst (
   .clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .trigger_pin(trigger_pin), .ext_count_pin(ext_count_pin), .otherTimerOverflow(otherTimerOverflow),
   .rxBaudPulse(rxBaudPulse), .txBaudPulse(txBaudPulse), .timerIrq(timerIrq));

`default_nettype wire

// ### verif/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // Pins and other timer
   output logic      trigger_pin,
   output logic      ext_count_pin,
   output logic      otherTimerOverflow,
   // Serial port baud clocks
   input  wire logic rxBaudPulse,
   input  wire logic txBaudPulse,
   output int        rxCount,
   output int        txCount
);
   logic [3:0] divider;

   // Pins rest on their pull-ups
   initial begin
      trigger_pin = 1'b1;
      ext_count_pin = 1'b1;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         divider            <= 4'h0;
         otherTimerOverflow <= 1'b0;
         rxCount            <= 0;
         txCount            <= 0;
      end else begin
         divider            <= divider + 4'h1;
         otherTimerOverflow <= (divider == 4'hf);
         rxCount            <= rxCount + int'(rxBaudPulse);
         txCount            <= txCount + int'(txBaudPulse);
      end
   end

   // Low long enough to pass the synchroniser, then high again
   task automatic pulse_pin(input logic trig);
      @(posedge clk_sys);
      if (trig) trigger_pin <= 1'b0;
      else ext_count_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      trigger_pin <= 1'b1;
      ext_count_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule // far_side_model

`default_nettype wire

// ### verif/timer2_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin fails++; \
   $display("BAD %s expected %h seen %h", what, exp, got); end end

module timer2_mode_control_bench
   import timer2_pkg::*;
;
   logic        clk_sys, reset, clkEnable, psel, penable, pwrite, pready, pslverr, lastErr;
   logic        trigger_pin, ext_count_pin, otherTimerOverflow, rxBaudPulse, txBaudPulse, timerIrq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [31:0] sel [2] = '{32'h14, 32'h24};
   int          fails, nTests, rxCount, txCount, r0, t0;

   timer2_mode_control timer2_mode_control_inst (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .trigger_pin(trigger_pin), .ext_count_pin(ext_count_pin),
      .otherTimerOverflow(otherTimerOverflow), .rxBaudPulse(rxBaudPulse), .txBaudPulse(txBaudPulse),
      .timerIrq(timerIrq));
   far_side_model far_side_model_inst (.clk_sys(clk_sys), .reset(reset), .trigger_pin(trigger_pin),
      .ext_count_pin(ext_count_pin), .otherTimerOverflow(otherTimerOverflow), .rxBaudPulse(rxBaudPulse),
      .txBaudPulse(txBaudPulse), .rxCount(rxCount), .txCount(txCount));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // APB master and helpers
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Idle edge at the end so the next call never reassigns psel in one step
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         end_of_test();
      end
      rdata   = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
      apb(1'b0, a, 32'h0);
      `CHECK(what, e, rdata)
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      clkEnable = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tick(8);
      reset <= 1'b0;
      tick(1);
      rd(ADDR_CONTROL, 32'h0, "control reset");
      rd(ADDR_COUNT, 32'h0, "count reset");
      rd(12'h0e0, 32'h0, "unmapped");
      `CHECK("slverr", 1'b1, lastErr)
      $display("test map done");
      wr(ADDR_COUNT, 32'h5a5a);
      wr(ADDR_CONTROL, 32'h09);
      far_side_model_inst.pulse_pin(1'b1);
      rd(ADDR_CAPTURE, 32'h5a5a, "capture");
      rd(ADDR_CONTROL, 32'h49, "ext flag");
      wr(ADDR_IRQMASK, 32'h2);
      tick(2);
      `CHECK("irq ext", 1'b1, timerIrq)
      wr(ADDR_MODE, 32'h1);
      tick(2);
      `CHECK("irq down", 1'b0, timerIrq)
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_CONTROL, 32'h08);
      wr(ADDR_IRQSTAT, 32'h2);
      wr(ADDR_CAPTURE, 32'h1111);
      far_side_model_inst.pulse_pin(1'b1);
      rd(ADDR_COUNT, 32'h1111, "reload");
      rd(ADDR_CONTROL, 32'h48, "reload flag");
      wr(ADDR_CONTROL, 32'h38);
      wr(ADDR_COUNT, 32'h2222);
      far_side_model_inst.pulse_pin(1'b1);
      rd(ADDR_COUNT, 32'h2222, "no reload");
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_IRQSTAT, 32'h3);
      $display("test trigger done");
      wr(ADDR_CAPTURE, 32'hfff0);
      wr(ADDR_COUNT, 32'hfffe);
      wr(ADDR_IRQMASK, 32'h1);
      wr(ADDR_CONTROL, 32'h04);
      tick(40);
      rd(ADDR_CONTROL, 32'h84, "overflow");
      `CHECK("irq ovf", 1'b1, timerIrq)
      apb(1'b0, ADDR_COUNT, 32'h0);
      `CHECK("wrap reload", 1'b1, rdata inside {[32'hfff0:32'hfff4]})
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_IRQSTAT, 32'h1);
      tick(2);
      `CHECK("irq clear", 1'b0, timerIrq)
      wr(ADDR_COUNT, 32'hfffe);
      wr(ADDR_CONTROL, 32'h34);
      r0 = rxCount;
      t0 = txCount;
      tick(400);
      wr(ADDR_CONTROL, 32'h30);
      rd(ADDR_CONTROL, 32'h30, "baud no flag");
      `CHECK("rx own", 1'b1, rxCount - r0 >= 2)
      `CHECK("tx own", rxCount - r0, txCount - t0)
      foreach (sel[i]) begin
         wr(ADDR_CONTROL, sel[i]);
         r0 = rxCount;
         t0 = txCount;
         tick(160);
         `CHECK("other", 1'b1, (sel[i][5] ? txCount - t0 : rxCount - r0) inside {[9:11]})
      end
      clkEnable <= 1'b0;
      tick(20);
      clkEnable <= 1'b1;
      wr(ADDR_CONTROL, 32'h0);
      $display("test overflow done");
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL, 32'h02);
      far_side_model_inst.pulse_pin(1'b0);
      rd(ADDR_COUNT, 32'h0, "stopped");
      wr(ADDR_CONTROL, 32'h06);
      repeat (3) far_side_model_inst.pulse_pin(1'b0);
      wr(ADDR_CONTROL, 32'h02);
      rd(ADDR_COUNT, 32'h3, "pin count");
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_MODE, m[1:0] << BIT_SIX_CLK);
         wr(ADDR_COUNT, 32'h0);
         wr(ADDR_CONTROL, 32'h04);
         tick(600);
         wr(ADDR_CONTROL, 32'h0);
         apb(1'b0, ADDR_COUNT, 32'h0);
         r0 = 603 / (m ? DIV_SIX : DIV_TWELVE);
         `CHECK("prescale", 1'b1, int'(rdata) inside {[r0 - 1:r0 + 1]})
      end
      $display("test count done");
      end_of_test();
   end
endmodule // timer2_mode_control_bench

`default_nettype wire
